// ---- design/eth_mac_upper_pkg.sv ----
// Purpose: shared constants and types for the MAC upper register bank
// Assumes: APB byte addresses, 32-bit data, 250 MHz mclk
// Notes: field positions, reset values and management frame layout
package eth_mac_upper_pkg;
  localparam logic [7:0] OFF_STATION_HIGH = 8'h08;
  localparam logic [7:0] OFF_STATION_LOW = 8'h0c;
  localparam logic [7:0] OFF_MGMT = 8'h10;
  localparam logic [7:0] OFF_TX_TABLE = 8'h14;
  localparam logic [7:0] OFF_RX_TABLE = 8'h18;
  localparam logic [7:0] OFF_DBG_IP = 8'h1c;
  localparam logic [7:0] OFF_HASH_UPPER = 8'h20;
  localparam logic [7:0] OFF_HASH_LOWER = 8'h24;
  localparam logic [7:0] OFF_DBG_MAC_UPPER = 8'h28;
  localparam logic [7:0] OFF_DBG_MAC_LOWER = 8'h2c;

  localparam int DATA_LSB = 16;
  localparam int PHYSEL_LSB = 11;
  localparam int REGSEL_LSB = 6;
  localparam int BUSY_BIT = 3;
  localparam int LF_BIT = 2;
  localparam int RD_BIT = 1;
  localparam int WR_BIT = 0;
  localparam int BASE_LSB = 10;
  localparam int IDX_LSB = 3;
  localparam int IDX_W = 7;
  localparam int HALF_W = 16;
  localparam int ADDR5_W = 5;
  localparam int STRAP_W = 4;

  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [4:0] PHYSEL_RST0 = 5'h01;
  localparam logic [4:0] PHYSEL_RST1 = 5'h02;
  localparam logic [4:0] REGSEL_RST = 5'h00;
  localparam logic LF_RST = 1'b1;
  localparam logic [6:0] IDX_RST = 7'h00;
  localparam logic [31:0] IP_RST0 = 32'hc0a80010;
  localparam logic [31:0] IP_RST1 = 32'hc0a80020;
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  localparam logic [31:0] MDIO_PREAMBLE = 32'hffffffff;
  localparam logic [1:0] MDIO_START = 2'h1;
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [1:0] MDIO_TA_WRITE = 2'h2;
  localparam logic [5:0] MDIO_RELEASE_BIT = 6'h2e;
  localparam logic [5:0] MDIO_TA_BIT = 6'h2f;
  localparam logic [5:0] MDIO_LAST_BIT = 6'h3f;

  localparam int CLK_NS = 4;
  localparam int MDC_HALF_NS = 200;
  localparam int MDC_HALF_CYC = (MDC_HALF_NS + CLK_NS - 1) / CLK_NS;

  typedef enum {MGMT_IDLE, MGMT_LOW, MGMT_HIGH} mgmtState_t;
endpackage : eth_mac_upper_pkg

// ---- design/eth_mac_upper_register_bank.sv ----
// Purpose: MAC upper register bank with PHY management engine, APB slave
// Assumes: single mclk domain, mdioIn and strap pins asynchronous
// Notes: station, hash and table base fields hold their value over reset
//
// The APB slave port is this design's own decision.
module eth_mac_upper_register_bank #(
  parameter bit INSTANCE = 1'b0,
  parameter int MDC_HALF = eth_mac_upper_pkg::MDC_HALF_CYC,
  // arbitrary neutral preset values
  parameter logic [15:0] DBG_MAC_UPPER_RST = 16'h0a0b,
  parameter logic [31:0] DBG_MAC_LOWER_RST0 = 32'h00c0ff10,
  parameter logic [31:0] DBG_MAC_LOWER_RST1 = 32'h00c0ff20
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic txDescAdvance,
  input wire logic rxDescAdvance,
  input wire logic ipStrapEnable,
  input wire logic [3:0] ipStrapBits,
  output logic mdc,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic mdioIn,
  output logic [47:0] stationAddress,
  output logic [63:0] multicastHash,
  output logic [31:0] txDescAddress,
  output logic [31:0] rxDescAddress,
  output logic [31:0] debugIpAddress,
  output logic [47:0] debugMacAddress
);

  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a >= eth_mac_upper_pkg::OFF_STATION_HIGH) && (a <= eth_mac_upper_pkg::OFF_DBG_MAC_LOWER)
      && (a[1:0] == 2'h0);
  endfunction : isMapped

  logic [31:0] stationLow_q;
  logic [15:0] stationHigh_q;
  logic [31:0] hashUpper_q;
  logic [31:0] hashLower_q;
  logic [21:0] txBase_q;
  logic [21:0] rxBase_q;
  logic [6:0] txIdx_q;
  logic [6:0] rxIdx_q;
  logic [31:0] dbgIp_q;
  logic [15:0] dbgMacUpper_q;
  logic [31:0] dbgMacLower_q;
  logic [15:0] mgmtData_q;
  logic [4:0] phySelect_q;
  logic [4:0] phyRegisterSelect_q;
  logic managementBusy_q;
  logic linkFailureFlag_q;
  logic opRead_q;
  logic [31:0] prdata_q;
  logic [4:0] strapSync1_q;
  logic [4:0] strapSync2_q;
  logic [1:0] strapWait_q;
  logic strapDone_q;
  logic mdioSync1_q;
  logic mdioSync2_q;
  eth_mac_upper_pkg::mgmtState_t mgmtState_q;
  logic [11:0] halfCnt_q;
  logic [5:0] bitCnt_q;
  logic [63:0] frame_q;
  logic [15:0] rdShift_q;
  logic mdc_q;
  logic mdioOe_q;
  logic [31:0] rdValue;
  logic wrEn;
  logic mgmtWr;
  logic startRead;
  logic startWrite;
  logic halfEnd;
  logic bitEnd;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  assign pready = psel && penable && ce;
  assign pslverr = pready && !isMapped(paddr);
  assign prdata = prdata_q;
  assign wrEn = pready && pwrite && isMapped(paddr);
  assign mgmtWr = wrEn && (paddr == eth_mac_upper_pkg::OFF_MGMT) && !managementBusy_q;
  // read wins if both start bits are set
  assign startRead = mgmtWr && pwdata[eth_mac_upper_pkg::RD_BIT];
  assign startWrite = mgmtWr && !pwdata[eth_mac_upper_pkg::RD_BIT] && pwdata[eth_mac_upper_pkg::WR_BIT];

  always_comb
  begin
    rdValue = 32'h00000000;
    case (paddr)
      eth_mac_upper_pkg::OFF_STATION_HIGH: rdValue = {16'h0000, stationHigh_q};
      eth_mac_upper_pkg::OFF_STATION_LOW: rdValue = stationLow_q;
      eth_mac_upper_pkg::OFF_MGMT: rdValue = {mgmtData_q, phySelect_q, phyRegisterSelect_q, 2'h0,
        managementBusy_q, linkFailureFlag_q, managementBusy_q && opRead_q, managementBusy_q && !opRead_q};
      eth_mac_upper_pkg::OFF_TX_TABLE: rdValue = txDescAddress;
      eth_mac_upper_pkg::OFF_RX_TABLE: rdValue = rxDescAddress;
      eth_mac_upper_pkg::OFF_DBG_IP: rdValue = dbgIp_q;
      eth_mac_upper_pkg::OFF_HASH_UPPER: rdValue = hashUpper_q;
      eth_mac_upper_pkg::OFF_HASH_LOWER: rdValue = hashLower_q;
      eth_mac_upper_pkg::OFF_DBG_MAC_UPPER: rdValue = {16'h0000, dbgMacUpper_q};
      eth_mac_upper_pkg::OFF_DBG_MAC_LOWER: rdValue = dbgMacLower_q;
      default: rdValue = 32'h00000000;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      prdata_q <= 32'h00000000;
    else if (ce && psel && !penable)
      prdata_q <= rdValue;
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage kept over reset
  always_ff @(posedge mclk)
  begin
    if (ce && wrEn)
    begin
      case (paddr)
        eth_mac_upper_pkg::OFF_STATION_LOW: stationLow_q <= pwdata;
        eth_mac_upper_pkg::OFF_STATION_HIGH: stationHigh_q <= pwdata[15:0];
        eth_mac_upper_pkg::OFF_HASH_UPPER: hashUpper_q <= pwdata;
        eth_mac_upper_pkg::OFF_HASH_LOWER: hashLower_q <= pwdata;
        eth_mac_upper_pkg::OFF_TX_TABLE: txBase_q <= pwdata[31:eth_mac_upper_pkg::BASE_LSB];
        eth_mac_upper_pkg::OFF_RX_TABLE: rxBase_q <= pwdata[31:eth_mac_upper_pkg::BASE_LSB];
        default: ;
      endcase
    end
  end

  assign stationAddress = {stationHigh_q, stationLow_q};
  assign multicastHash = {hashUpper_q, hashLower_q};
  assign txDescAddress = {txBase_q, txIdx_q, 3'h0};
  assign rxDescAddress = {rxBase_q, rxIdx_q, 3'h0};

  ////////////////////////////////////////////////////////////////////////////
  // descriptor index: advance is applied on top of a same-cycle write
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      txIdx_q <= eth_mac_upper_pkg::IDX_RST;
      rxIdx_q <= eth_mac_upper_pkg::IDX_RST;
    end
    else if (ce)
    begin
      txIdx_q <= ((wrEn && paddr == eth_mac_upper_pkg::OFF_TX_TABLE) ?
        pwdata[eth_mac_upper_pkg::IDX_LSB +: eth_mac_upper_pkg::IDX_W] : txIdx_q) + 7'(txDescAdvance);
      rxIdx_q <= ((wrEn && paddr == eth_mac_upper_pkg::OFF_RX_TABLE) ?
        pwdata[eth_mac_upper_pkg::IDX_LSB +: eth_mac_upper_pkg::IDX_W] : rxIdx_q) + 7'(rxDescAdvance);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // debug link address registers and strap
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      strapSync1_q <= 5'h00;
      strapSync2_q <= 5'h00;
      strapWait_q <= 2'h0;
      strapDone_q <= 1'b0;
    end
    else if (ce)
    begin
      strapSync1_q <= {ipStrapEnable, ipStrapBits};
      strapSync2_q <= strapSync1_q;
      if (strapWait_q != eth_mac_upper_pkg::STRAP_SETTLE)
        strapWait_q <= strapWait_q + 2'h1;
      else
        strapDone_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      dbgIp_q <= INSTANCE ? eth_mac_upper_pkg::IP_RST1 : eth_mac_upper_pkg::IP_RST0;
      dbgMacUpper_q <= DBG_MAC_UPPER_RST;
      dbgMacLower_q <= INSTANCE ? DBG_MAC_LOWER_RST1 : DBG_MAC_LOWER_RST0;
    end
    else if (ce)
    begin
      if (wrEn && paddr == eth_mac_upper_pkg::OFF_DBG_IP)
        dbgIp_q <= pwdata;
      else if (!strapDone_q && strapWait_q == eth_mac_upper_pkg::STRAP_SETTLE && strapSync2_q[4])
        dbgIp_q[eth_mac_upper_pkg::STRAP_W-1:0] <= strapSync2_q[3:0];
      if (wrEn && paddr == eth_mac_upper_pkg::OFF_DBG_MAC_UPPER)
        dbgMacUpper_q <= pwdata[15:0];
      if (wrEn && paddr == eth_mac_upper_pkg::OFF_DBG_MAC_LOWER)
        dbgMacLower_q <= pwdata;
    end
  end

  assign debugIpAddress = dbgIp_q;
  assign debugMacAddress = {dbgMacUpper_q, dbgMacLower_q};

  ////////////////////////////////////////////////////////////////////////////
  // management command fields
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mgmtData_q <= eth_mac_upper_pkg::DATA_RST;
      phySelect_q <= INSTANCE ? eth_mac_upper_pkg::PHYSEL_RST1 : eth_mac_upper_pkg::PHYSEL_RST0;
      phyRegisterSelect_q <= eth_mac_upper_pkg::REGSEL_RST;
    end
    else if (ce)
    begin
      if (mgmtWr)
      begin
        mgmtData_q <= pwdata[eth_mac_upper_pkg::DATA_LSB +: eth_mac_upper_pkg::HALF_W];
        phySelect_q <= pwdata[eth_mac_upper_pkg::PHYSEL_LSB +: eth_mac_upper_pkg::ADDR5_W];
        phyRegisterSelect_q <= pwdata[eth_mac_upper_pkg::REGSEL_LSB +: eth_mac_upper_pkg::ADDR5_W];
      end
      else if (bitEnd && bitCnt_q == eth_mac_upper_pkg::MDIO_LAST_BIT && opRead_q)
        mgmtData_q <= {rdShift_q[14:0], mdioSync2_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // management frame engine
  assign halfEnd = (halfCnt_q == 12'(MDC_HALF - 1));
  assign bitEnd = (mgmtState_q == eth_mac_upper_pkg::MGMT_HIGH) && halfEnd;

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mdioSync1_q <= 1'b1;
      mdioSync2_q <= 1'b1;
    end
    else if (ce)
    begin
      mdioSync1_q <= mdioIn;
      mdioSync2_q <= mdioSync1_q;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      mgmtState_q <= eth_mac_upper_pkg::MGMT_IDLE;
      halfCnt_q <= 12'h000;
      bitCnt_q <= 6'h00;
      frame_q <= 64'h0000000000000000;
      rdShift_q <= 16'h0000;
      mdc_q <= 1'b0;
      mdioOe_q <= 1'b0;
      managementBusy_q <= 1'b0;
      linkFailureFlag_q <= eth_mac_upper_pkg::LF_RST;
      opRead_q <= 1'b0;
    end
    else if (ce)
    begin
      case (mgmtState_q)
        eth_mac_upper_pkg::MGMT_IDLE:
        begin
          if (startRead || startWrite)
          begin
            mgmtState_q <= eth_mac_upper_pkg::MGMT_LOW;
            managementBusy_q <= 1'b1;
            opRead_q <= startRead;
            halfCnt_q <= 12'h000;
            bitCnt_q <= 6'h00;
            mdioOe_q <= 1'b1;
            frame_q <= {eth_mac_upper_pkg::MDIO_PREAMBLE, eth_mac_upper_pkg::MDIO_START,
              startRead ? eth_mac_upper_pkg::MDIO_OP_READ : eth_mac_upper_pkg::MDIO_OP_WRITE,
              pwdata[eth_mac_upper_pkg::PHYSEL_LSB +: eth_mac_upper_pkg::ADDR5_W],
              pwdata[eth_mac_upper_pkg::REGSEL_LSB +: eth_mac_upper_pkg::ADDR5_W],
              eth_mac_upper_pkg::MDIO_TA_WRITE,
              pwdata[eth_mac_upper_pkg::DATA_LSB +: eth_mac_upper_pkg::HALF_W]};
          end
        end
        eth_mac_upper_pkg::MGMT_LOW:
        begin
          halfCnt_q <= halfEnd ? 12'h000 : halfCnt_q + 12'h001;
          if (halfEnd)
          begin
            mgmtState_q <= eth_mac_upper_pkg::MGMT_HIGH;
            mdc_q <= 1'b1;
          end
        end
        eth_mac_upper_pkg::MGMT_HIGH:
        begin
          halfCnt_q <= halfEnd ? 12'h000 : halfCnt_q + 12'h001;
          if (halfEnd)
          begin
            mdc_q <= 1'b0;
            frame_q <= {frame_q[62:0], 1'b0};
            rdShift_q <= {rdShift_q[14:0], mdioSync2_q};
            bitCnt_q <= bitCnt_q + 6'h01;
            if (opRead_q && bitCnt_q + 6'h01 == eth_mac_upper_pkg::MDIO_RELEASE_BIT)
              mdioOe_q <= 1'b0;
            if (bitCnt_q == eth_mac_upper_pkg::MDIO_TA_BIT && opRead_q)
              linkFailureFlag_q <= mdioSync2_q;
            if (bitCnt_q == eth_mac_upper_pkg::MDIO_LAST_BIT)
            begin
              mgmtState_q <= eth_mac_upper_pkg::MGMT_IDLE;
              managementBusy_q <= 1'b0;
              mdioOe_q <= 1'b0;
              if (!opRead_q)
                linkFailureFlag_q <= 1'b0;
            end
            else
              mgmtState_q <= eth_mac_upper_pkg::MGMT_LOW;
          end
        end
        default: mgmtState_q <= eth_mac_upper_pkg::MGMT_IDLE;
      endcase
    end
  end

  assign mdc = mdc_q;
  assign mdioOut = frame_q[63];
  assign mdioOe = mdioOe_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_BUSY_START: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && (startRead || startWrite)) |=> managementBusy_q)
    else $error("busy not set after start");

  AST_BUSY_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
    $rose(managementBusy_q) |-> managementBusy_q [*8])
    else $error("busy dropped early");

  AST_IDLE_LINE: assert property (@(posedge mclk) disable iff (!nrst)
    !managementBusy_q |-> (!mdc && !mdioOe && mgmtState_q == eth_mac_upper_pkg::MGMT_IDLE))
    else $error("management line active while idle");

  AST_LF_STABLE: assert property (@(posedge mclk) disable iff (!nrst)
    (!managementBusy_q && $past(!managementBusy_q)) |-> $stable(linkFailureFlag_q))
    else $error("link failure flag changed while idle");

  AST_WRITE_DATA: assert property (@(posedge mclk) disable iff (!nrst)
    (managementBusy_q && $past(managementBusy_q) && !opRead_q) |-> $stable(mgmtData_q))
    else $error("data field changed during write");

  AST_PREAMBLE: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && (startRead || startWrite)) |=> (mdioOut && mdioOe) [*8])
    else $error("preamble not driven");

  AST_READ_RELEASE: assert property (@(posedge mclk) disable iff (!nrst)
    (managementBusy_q && opRead_q && bitCnt_q > eth_mac_upper_pkg::MDIO_RELEASE_BIT) |-> !mdioOe)
    else $error("line driven during read turnaround");

  AST_PTR_ADV: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && txDescAdvance && !(wrEn && paddr == eth_mac_upper_pkg::OFF_TX_TABLE))
      |=> txIdx_q == $past(txIdx_q) + 7'h01)
    else $error("descriptor index did not advance");

  AST_PHYSEL: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && mgmtWr) |=> phySelect_q == $past(pwdata[15:11]) && phyRegisterSelect_q == $past(pwdata[10:6]))
    else $error("select fields not written");

  AST_HASH: assert property (@(posedge mclk) disable iff (!nrst)
    (ce && wrEn && paddr == eth_mac_upper_pkg::OFF_HASH_UPPER) |=> multicastHash[63:32] == $past(pwdata))
    else $error("hash upper half not written");

  AST_SLVERR: assert property (@(posedge mclk) disable iff (!nrst)
    (pready && isMapped(paddr)) |-> !pslverr)
    else $error("error on mapped address");

endmodule : eth_mac_upper_register_bank

// ---- sim/mdio_phy_model.sv ----
// Purpose: behavioural PHY on the management interface
// Assumes: 64-bit frames, station launches bits on mdc falling
// Notes: line has a pull-up, so a released line reads one
module mdio_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  input wire logic mdc,
  input wire logic mdioOe,
  input wire logic mdioOut,
  output logic phyOe,
  output logic phyOut,
  output logic frameErr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [0:63] fr;
  logic [15:0] regs [32];
  int bitNo;
  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = 16'h3c00 | 16'(i);
    phyOe = 1'b0;
    phyOut = 1'b1;
    frameErr = 1'b0;
    bitNo = 64;
  end
  always @(posedge mdioOe)
  begin
    bitNo = 0;
    phyOe = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // answer reads: turnaround zero, then data msb first
  always @(negedge mdc)
  begin
    bitNo++;
    phyOe = 1'b0;
    if (fr[34:35] == 2'b10 && fr[36:40] == PHY_ADDR && bitNo >= 47 && bitNo <= 63)
    begin
      phyOe = 1'b1;
      phyOut = (bitNo == 47) ? 1'b0 : regs[fr[41:45]][63 - bitNo];
    end
  end
  ////////////////////////////////////////////////////////////////
  // capture station bits, check framing, commit writes
  always @(posedge mdc)
  begin
    if (mdioOe && bitNo < 64)
      fr[bitNo] = mdioOut;
    if (bitNo == 33 && fr[0:33] != {32'hffffffff, 2'h1})
      frameErr = 1'b1;
    if (bitNo == 63 && fr[34:35] == 2'b01)
    begin
      if (fr[46:47] != 2'b10)
        frameErr = 1'b1;
      if (fr[36:40] == PHY_ADDR)
        regs[fr[41:45]] = fr[48:63];
    end
  end
endmodule : mdio_phy_model

// ---- sim/eth_mac_upper_register_bank_tb_top.sv ----
// Purpose: self-checking bench for the MAC upper register bank
// Assumes: APB master with zero-wait slave, mdc half period of 2 cycles
// Notes: management line resolved here with a pull-up
module eth_mac_upper_register_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MDC_HALF = 2;
  localparam int OP_CYC = 128 * MDC_HALF;
  logic mclk, nrst, ce, psel, penable, pwrite, txDescAdvance, rxDescAdvance, ipStrapEnable;
  logic pready, pslverr, mdc, mdioOut, mdioOe, mdioIn, phyOe, phyOut, frameErr;
  logic [7:0] paddr;
  logic [3:0] ipStrapBits;
  logic [31:0] pwdata, prdata, txDescAddress, rxDescAddress, debugIpAddress;
  logic [47:0] stationAddress, debugMacAddress;
  logic [63:0] multicastHash;
  int errCount, testsRun, cyc;
  assign mdioIn = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
  always #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  eth_mac_upper_register_bank #(.MDC_HALF(MDC_HALF)) eth_mac_upper_register_bank_i (.mclk(mclk), .nrst(nrst),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txDescAdvance(txDescAdvance), .rxDescAdvance(rxDescAdvance),
    .ipStrapEnable(ipStrapEnable), .ipStrapBits(ipStrapBits), .mdc(mdc), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .mdioIn(mdioIn), .stationAddress(stationAddress), .multicastHash(multicastHash),
    .txDescAddress(txDescAddress), .rxDescAddress(rxDescAddress), .debugIpAddress(debugIpAddress),
    .debugMacAddress(debugMacAddress));
  mdio_phy_model mdio_phy_model_i (.mdc(mdc), .mdioOe(mdioOe), .mdioOut(mdioOut), .phyOe(phyOe),
    .phyOut(phyOut), .frameErr(frameErr));
  ////////////////////////////////////////////////////////////////
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tallyAndFinish
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      errCount++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      errCount++;
      $display("ERROR pready expected 1 seen 0");
      tallyAndFinish();
    end
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, exp, q & m);
  endtask : rd
  task automatic doReset(input logic strap);
    @(posedge mclk);
    nrst <= 1'b0;
    ipStrapEnable <= strap;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask : doReset
  function automatic logic [31:0] mword(logic [15:0] d, logic [4:0] p, logic [4:0] r, logic [1:0] op);
    return {d, p, r, 4'h0, op};
  endfunction : mword
  ////////////////////////////////////////////////////////////////
  task automatic resetValues();
    rd(8'h10, 32'hffffffff, 32'h00000804, "mgmt reset");
    rd(8'h1c, 32'hffffffff, 32'hc0a80010, "ip reset");
    rd(8'h28, 32'hffffffff, 32'h00000a0b, "dbg mac hi reset");
    rd(8'h2c, 32'hffffffff, 32'h00c0ff10, "dbg mac lo reset");
    rd(8'h14, 32'h000003ff, 32'h0, "tx index reset");
    rd(8'h18, 32'h000003ff, 32'h0, "rx index reset");
  endtask : resetValues
  task automatic rwRegs();
    logic [7:0] ad [9] = '{8'h08, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c};
    logic [31:0] mk [9] = '{32'hffff, '1, 32'hfffffff8, 32'hfffffff8, '1, '1, '1, 32'hffff, '1};
    logic [31:0] d [9];
    logic [31:0] q;
    logic e;
    for (int i = 0; i < 9; i++)
      d[i] = 32'h8f1e2d3c + 32'h11111111 * 32'(i);
    for (int i = 0; i < 9; i++)
      wr(ad[i], d[i]);
    for (int i = 0; i < 9; i++)
      rd(ad[i], '1, d[i] & mk[i], "rw readback");
    chk("station hi", {16'h0, d[0][15:0]}, {16'h0, stationAddress[47:32]});
    chk("station lo", d[1], stationAddress[31:0]);
    chk("hash hi", d[5], multicastHash[63:32]);
    chk("hash lo", d[6], multicastHash[31:0]);
    chk("dbg mac lo", d[8], debugMacAddress[31:0]);
    chk("tx addr", d[2] & mk[2], txDescAddress);
    chk("rx addr", d[3] & mk[3], rxDescAddress);
    chk("dbg ip out", d[4], debugIpAddress);
    chk("dbg mac hi", {16'h0, d[7][15:0]}, {16'h0, debugMacAddress[47:32]});
    doReset(1'b1);
    rd(8'h0c, '1, d[1], "station kept");
    rd(8'h08, '1, d[0] & mk[0], "station hi kept");
    rd(8'h20, '1, d[5], "hash kept");
    rd(8'h14, 32'hfffffc00, d[2] & 32'hfffffc00, "tx base kept");
    rd(8'h18, 32'hfffffc00, d[3] & 32'hfffffc00, "rx base kept");
    rd(8'h1c, '1, 32'hc0a80019, "ip strap");
    chk("ip strap out", 32'hc0a80019, debugIpAddress);
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk("unmapped read err", 32'h1, {31'h0, e});
    chk("unmapped read data", 32'h0, q);
    apb(1'b1, 8'h0d, '1, q, e);
    chk("unaligned write err", 32'h1, {31'h0, e});
  endtask : rwRegs
  task automatic descIndex();
    wr(8'h14, 32'habcde7f8);
    @(posedge mclk);
    txDescAdvance <= 1'b1;
    @(posedge mclk);
    txDescAdvance <= 1'b0;
    rd(8'h14, '1, 32'habcde400, "tx index wrap");
    chk("tx addr out", 32'habcde400, txDescAddress);
    wr(8'h18, 32'h12345400);
    @(posedge mclk);
    rxDescAdvance <= 1'b1;
    repeat (2) @(posedge mclk);
    rxDescAdvance <= 1'b0;
    rd(8'h18, '1, 32'h12345410, "rx index twice");
    @(posedge mclk);
    ce <= 1'b0;
    rxDescAdvance <= 1'b1;
    @(posedge mclk);
    ce <= 1'b1;
    rxDescAdvance <= 1'b0;
    rd(8'h18, '1, 32'h12345410, "rx index frozen");
  endtask : descIndex
  task automatic mgmtOp(input logic [31:0] cmd, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    int t0;
    int n;
    wr(eth_mac_upper_pkg::OFF_MGMT, cmd);
    t0 = cyc;
    apb(1'b0, eth_mac_upper_pkg::OFF_MGMT, 32'h0, q, e);
    chk({what, " busy"}, {28'h0, 2'b10, cmd[1:0]}, {28'h0, q[3], 1'b0, q[1:0]});
    wr(eth_mac_upper_pkg::OFF_MGMT, cmd ^ 32'h000007c0);
    n = 0;
    while (q[3] !== 1'b0 && n < 200)
    begin
      apb(1'b0, eth_mac_upper_pkg::OFF_MGMT, 32'h0, q, e);
      n++;
    end
    chk(what, exp, q);
    chk({what, " time"}, 32'h1, {31'h0, (cyc - t0 >= OP_CYC - 4) && (cyc - t0 <= OP_CYC + 8)});
    chk({what, " line idle"}, 32'h0, {29'h0, mdc, mdioOe, frameErr});
  endtask : mgmtOp
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    errCount++;
    tallyAndFinish();
  end
  initial
  begin
    mclk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    txDescAdvance = 1'b0;
    rxDescAdvance = 1'b0;
    ipStrapEnable = 1'b0;
    ipStrapBits = 4'h9;
    errCount = 0;
    testsRun = 0;
    cyc = 0;
    doReset(1'b0);
    resetValues();
    rwRegs();
    descIndex();
    mgmtOp(mword(16'hbeef, 5'h01, 5'h05, 2'b01), mword(16'hbeef, 5'h01, 5'h05, 2'b00), "phy write");
    mgmtOp(mword(16'h0, 5'h01, 5'h05, 2'b10), mword(16'hbeef, 5'h01, 5'h05, 2'b00), "phy read");
    mgmtOp(mword(16'h0, 5'h01, 5'h02, 2'b10), mword(16'h3c02, 5'h01, 5'h02, 2'b00), "phy preset");
    mgmtOp(mword(16'h0, 5'h03, 5'h05, 2'b10), mword(16'hffff, 5'h03, 5'h05, 2'b00) | 32'h4, "no phy");
    mgmtOp(mword(16'h1357, 5'h01, 5'h09, 2'b01), mword(16'h1357, 5'h01, 5'h09, 2'b00), "fail clear");
    tallyAndFinish();
  end
endmodule : eth_mac_upper_register_bank_tb_top
